// File: common/utxdt_if.sv
`timescale 1ns/1ps
interface utxdt_if;
    logic reg_wr;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic push;
    logic [7:0] push_data;
    logic dma_req;
    logic fifo_full;
    modport dev (input reg_wr, input reg_addr, input reg_wdata, output reg_rdata,
                 input push, input push_data, output dma_req, output fifo_full);
    modport ctl (output reg_wr, output reg_addr, output reg_wdata, input reg_rdata,
                 output push, output push_data, input dma_req, input fifo_full);
endinterface : utxdt_if

// File: common/utxdt_pkg.sv
package utxdt_pkg;
    // ************************************************************
    // register offsets (byte addresses on the device port)
    // ************************************************************
    localparam logic [7:0] ADDR_FIFO_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_ENHANCED_FEATURE = 8'h08;
    localparam logic [7:0] ADDR_LINE_CONTROL = 8'h0C;
    localparam logic [7:0] ADDR_MODEM_CONTROL = 8'h10;
    localparam logic [7:0] ADDR_TRIGGER_LEVEL = 8'h1C;
    localparam logic [7:0] ADDR_SUPPLEMENTARY = 8'h40;
    localparam logic [7:0] ADDR_MODE_DEF_THREE = 8'h80;
    localparam logic [7:0] ADDR_TX_DMA_THRESHOLD = 8'h84;
    localparam logic [7:0] ADDR_TX_FIFO_LEVEL = 8'h88;
    // ************************************************************
    // key values and field positions
    // ************************************************************
    localparam logic [7:0] LINE_CONTROL_ENHANCED_MAP = 8'hBF;
    localparam logic [7:0] LINE_CONTROL_NORMAL_MAP = 8'h00;
    localparam int ENHANCED_UNLOCK_BIT = 4;
    localparam int TRIGGER_UNIT_GRAN_BIT = 6;
    localparam int TRIGGER_ACCESS_BIT = 6;
    localparam int DMA_THRESHOLD_EN_BIT = 2;
    localparam int FIFO_TRIG_LSB = 4;
    localparam int THRESHOLD_WIDTH = 6;
    localparam logic [5:0] THRESHOLD_EXAMPLE = 6'h3E;
    localparam logic [5:0] THRESHOLD_DEFAULT = 6'h20;
    localparam int FIFO_DEPTH = 64;
    localparam int LEVEL_WIDTH = 7;
    localparam logic [6:0] FIFO_SUM_LIMIT = 7'h3F;
    // ************************************************************
    // controller command register map on apb
    // ************************************************************
    localparam logic [11:0] APB_CMD = 12'h000;
    localparam logic [11:0] APB_STATUS = 12'h004;
    localparam logic [11:0] APB_THRESHOLD = 12'h008;
    localparam logic [11:0] APB_TRIGGER = 12'h00C;
    localparam logic [11:0] APB_LEVEL = 12'h010;
endpackage : utxdt_pkg

// File: hdl/utxdt_controller.sv
`timescale 1ns/1ps
module utxdt_controller (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link to device
    utxdt_if.ctl link,
    // data source
    input wire logic src_valid,
    input wire logic [7:0] src_data,
    output logic src_ready
);
    import utxdt_pkg::*;

    typedef enum {S_IDLE, S_LCR_BF, S_EFR, S_LCR_00, S_SCR, S_MCR, S_TLR, S_FCR, S_MDR,
                  S_THR, S_RUN} utxdt_state_t;
    utxdt_state_t state;
    logic [5:0] threshold;
    logic [5:0] trigger;
    logic run;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;

    wire acc = psel && penable;
    wire wcmd = acc && pwrite && paddr == APB_CMD;
    // start is refused unless threshold + trigger is within 63
    wire sum_ok = ({1'b0, threshold} + {1'b0, trigger}) <= FIFO_SUM_LIMIT;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // ************************************************************
    // apb registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            threshold <= THRESHOLD_EXAMPLE;
            trigger <= 6'h01;
        end else if (acc && pwrite && state == S_IDLE) begin
            if (paddr == APB_THRESHOLD) threshold <= pwdata[5:0];
            if (paddr == APB_TRIGGER) trigger <= pwdata[5:0];
        end
    end

    always_comb begin
        case (paddr)
            APB_STATUS: prdata = {28'h0, link.fifo_full, link.dma_req, sum_ok, run};
            APB_THRESHOLD: prdata = {26'h0, threshold};
            APB_TRIGGER: prdata = {26'h0, trigger};
            default: prdata = 32'h0;
        endcase
    end

    // ************************************************************
    // setup sequence
    // ************************************************************
    always_comb begin
        case (state)
            S_LCR_BF: begin wr_addr = ADDR_LINE_CONTROL; wr_data = LINE_CONTROL_ENHANCED_MAP; end
            S_EFR: begin wr_addr = ADDR_ENHANCED_FEATURE; wr_data = 8'h10; end
            S_LCR_00: begin wr_addr = ADDR_LINE_CONTROL; wr_data = LINE_CONTROL_NORMAL_MAP; end
            S_SCR: begin wr_addr = ADDR_SUPPLEMENTARY; wr_data = 8'h40; end
            S_MCR: begin wr_addr = ADDR_MODEM_CONTROL; wr_data = 8'h40; end
            S_TLR: begin wr_addr = ADDR_TRIGGER_LEVEL; wr_data = {4'h0, trigger[5:2]}; end
            S_FCR: begin wr_addr = ADDR_FIFO_CONTROL; wr_data = {2'b00, trigger[1:0], 4'h0}; end
            S_MDR: begin wr_addr = ADDR_MODE_DEF_THREE; wr_data = 8'h04; end
            S_THR: begin wr_addr = ADDR_TX_DMA_THRESHOLD; wr_data = {2'b00, threshold}; end
            default: begin wr_addr = 8'h00; wr_data = 8'h00; end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= S_IDLE;
            run <= 1'b0;
        end else begin
            case (state)
                S_IDLE: if (wcmd && pwdata[0] && sum_ok) state <= S_LCR_BF;
                S_LCR_BF: state <= S_EFR;
                S_EFR: state <= S_LCR_00;
                S_LCR_00: state <= S_SCR;
                S_SCR: state <= S_MCR;
                S_MCR: state <= S_TLR;
                S_TLR: state <= S_FCR;
                S_FCR: state <= S_MDR;
                S_MDR: state <= S_THR;
                S_THR: begin state <= S_RUN; run <= 1'b1; end
                S_RUN: if (wcmd && !pwdata[0]) begin state <= S_IDLE; run <= 1'b0; end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ************************************************************
    // link drive
    // ************************************************************
    assign link.reg_wr = state != S_IDLE && state != S_RUN;
    assign link.reg_addr = wr_addr;
    assign link.reg_wdata = wr_data;
    assign src_ready = run && link.dma_req;
    assign link.push = src_valid && src_ready;
    assign link.push_data = src_data;
endmodule : utxdt_controller

// File: hdl/utxdt_device.sv
`timescale 1ns/1ps
module utxdt_device #(
    parameter int DEPTH = utxdt_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link to controller
    utxdt_if.dev link,
    // transmit side drain
    input wire logic tx_pop,
    output logic [7:0] tx_data,
    output logic [utxdt_pkg::LEVEL_WIDTH-1:0] tx_level
);
    import utxdt_pkg::*;

    // ************************************************************
    // configuration registers
    // ************************************************************
    logic [7:0] line_control_reg;
    logic [7:0] enhanced_feature_reg;
    logic [7:0] fifo_control_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] trigger_level_reg;
    logic [7:0] supplementary_control_reg;
    logic [7:0] mode_definition_reg_three;
    logic [7:0] tx_dma_threshold_reg;
    logic [7:0] mem [DEPTH];
    logic [5:0] rd_ptr;
    logic [5:0] wr_ptr;
    logic [LEVEL_WIDTH-1:0] level;
    logic [LEVEL_WIDTH-1:0] burst_left;
    logic req;

    wire enhanced_map = line_control_reg == LINE_CONTROL_ENHANCED_MAP;
    wire enhanced_write_unlock = enhanced_feature_reg[ENHANCED_UNLOCK_BIT];
    wire trigger_access = enhanced_write_unlock && modem_control_reg[TRIGGER_ACCESS_BIT];
    wire tx_trigger_unit_granularity = supplementary_control_reg[TRIGGER_UNIT_GRAN_BIT];
    wire wr = link.reg_wr;
    wire [7:0] a = link.reg_addr;
    wire [7:0] d = link.reg_wdata;
    wire wr_lcr = wr && a == ADDR_LINE_CONTROL;
    wire wr_efr = wr && a == ADDR_ENHANCED_FEATURE && enhanced_map;
    wire wr_fcr = wr && a == ADDR_FIFO_CONTROL && !enhanced_map;
    wire wr_mcr = wr && a == ADDR_MODEM_CONTROL && enhanced_write_unlock;
    wire wr_tlr = wr && a == ADDR_TRIGGER_LEVEL && trigger_access;
    wire wr_scr = wr && a == ADDR_SUPPLEMENTARY;
    wire wr_mdr = wr && a == ADDR_MODE_DEF_THREE;
    wire wr_thr = wr && a == ADDR_TX_DMA_THRESHOLD;

    // ************************************************************
    // trigger level and threshold
    // ************************************************************
    // single granularity: concatenate nibble and fifo field; else units of four
    wire [5:0] gran_level = {trigger_level_reg[3:0], fifo_control_reg[FIFO_TRIG_LSB+:2]};
    wire [LEVEL_WIDTH-1:0] trig_unit = {1'b0, gran_level};
    wire [LEVEL_WIDTH-1:0] trig_coarse = {1'b0, trigger_level_reg[3:0], 2'b00};
    wire [LEVEL_WIDTH-1:0] trigger_level = tx_trigger_unit_granularity ? trig_unit : trig_coarse;
    wire [LEVEL_WIDTH-1:0] trig_eff = (trigger_level == '0) ? 7'h01 : trigger_level;
    wire [5:0] thr_field = tx_dma_threshold_reg[THRESHOLD_WIDTH-1:0];
    wire [LEVEL_WIDTH-1:0] threshold =
        {1'b0, mode_definition_reg_three[DMA_THRESHOLD_EN_BIT] ? thr_field : THRESHOLD_DEFAULT};
    wire full = level == LEVEL_WIDTH'(DEPTH);
    wire do_push = link.push && !full;
    wire do_pop = tx_pop && level != '0;

    // ************************************************************
    // register writes
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            line_control_reg <= 8'h00;
            enhanced_feature_reg <= 8'h00;
            fifo_control_reg <= 8'h00;
            modem_control_reg <= 8'h00;
            trigger_level_reg <= 8'h00;
            supplementary_control_reg <= 8'h00;
            mode_definition_reg_three <= 8'h00;
            tx_dma_threshold_reg <= 8'h00;
        end else begin
            if (wr_lcr) line_control_reg <= d;
            if (wr_efr) enhanced_feature_reg <= d;
            if (wr_fcr) fifo_control_reg <= d;
            if (wr_mcr) modem_control_reg <= d;
            if (wr_tlr) trigger_level_reg <= d;
            if (wr_scr) supplementary_control_reg <= d;
            if (wr_mdr) mode_definition_reg_three <= d;
            if (wr_thr) tx_dma_threshold_reg <= d;
        end
    end

    // ************************************************************
    // read back
    // ************************************************************
    always_comb begin
        case (a)
            ADDR_LINE_CONTROL: link.reg_rdata = line_control_reg;
            ADDR_FIFO_CONTROL: link.reg_rdata = enhanced_map ? enhanced_feature_reg : fifo_control_reg;
            ADDR_MODEM_CONTROL: link.reg_rdata = modem_control_reg;
            ADDR_TRIGGER_LEVEL: link.reg_rdata = trigger_level_reg;
            ADDR_SUPPLEMENTARY: link.reg_rdata = supplementary_control_reg;
            ADDR_MODE_DEF_THREE: link.reg_rdata = mode_definition_reg_three;
            ADDR_TX_DMA_THRESHOLD: link.reg_rdata = tx_dma_threshold_reg;
            ADDR_TX_FIFO_LEVEL: link.reg_rdata = {1'b0, level};
            default: link.reg_rdata = 8'h00;
        endcase
    end

    // ************************************************************
    // transmit fifo
    // ************************************************************
    always_ff @(posedge clk) begin
        if (do_push) mem[wr_ptr] <= link.push_data;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            level <= '0;
            tx_data <= 8'h00;
        end else begin
            if (do_push) wr_ptr <= wr_ptr + 6'h01;
            if (do_pop) rd_ptr <= rd_ptr + 6'h01;
            if (do_pop) tx_data <= mem[rd_ptr];
            level <= level + LEVEL_WIDTH'(do_push) - LEVEL_WIDTH'(do_pop);
        end
    end

    // ************************************************************
    // dma request
    // ************************************************************
    // request stands until trigger-level entries have been pushed
    always_ff @(posedge clk) begin
        if (rst) begin
            req <= 1'b0;
            burst_left <= '0;
        end else if (req) begin
            if (do_push && burst_left == 7'h01) req <= 1'b0;
            if (do_push) burst_left <= burst_left - 7'h01;
        end else if (level < threshold) begin
            req <= 1'b1;
            burst_left <= trig_eff;
        end
    end

    assign link.dma_req = req;
    assign link.fifo_full = full;
    assign tx_level = level;
endmodule : utxdt_device

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import utxdt_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic src_valid = 1'b1;
    logic [7:0] src_data = 8'h00;
    logic src_ready;
    logic tx_pop = 1'b0;
    logic [7:0] tx_data;
    logic [LEVEL_WIDTH-1:0] tx_level;
    logic [31:0] rd;
    logic [7:0] exp_pop = 8'h00;
    logic [15:0] wq[$];
    int errors = 0;
    int total_checks = 0;
    always #20 clk = ~clk;
    utxdt_if link ();
    utxdt_controller i_utxdt_controller (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link), .src_valid(src_valid), .src_data(src_data),
        .src_ready(src_ready));
    utxdt_device i_utxdt_device (.clk(clk), .rst(rst), .link(link), .tx_pop(tx_pop),
        .tx_data(tx_data), .tx_level(tx_level));
    utxdt_assertions i_utxdt_assertions (.clk(clk), .rst(rst), .reg_wr(link.reg_wr),
        .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .push(link.push),
        .dma_req(link.dma_req));
    // ************************************************************
    // monitors and source
    // ************************************************************
    always @(posedge clk) begin
        if (link.reg_wr === 1'b1) begin
            wq.push_back({link.reg_addr, link.reg_wdata});
        end
        if (src_valid === 1'b1 && src_ready === 1'b1) begin
            src_data <= src_data + 8'h01;
        end
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic run_cfg(input logic [5:0] thr, input logic [5:0] trig);
        logic [15:0] e [9];
        int n;
        e = '{16'h0CBF, 16'h0810, 16'h0C00, 16'h4040, 16'h1040, {12'h1C0, trig[5:2]},
              {10'h020, trig[1:0], 4'h0}, 16'h8004, {10'h210, thr}};
        wq.delete();
        apb(1'b1, APB_THRESHOLD, {26'h0, thr});
        apb(1'b1, APB_TRIGGER, {26'h0, trig});
        apb(1'b1, APB_CMD, 32'h1);
        repeat (12) @(posedge clk);
        chk("setup count", 9, wq.size());
        for (int i = 0; i < 9; i++) begin
            chk("setup write", e[i], (i < wq.size()) ? wq[i] : 16'hXXXX);
        end
        n = 0;
        while (!(tx_level >= thr) && n < 1000) begin
            @(posedge clk);
            n++;
        end
        repeat (20) @(posedge clk);
        chk("level band", 1, tx_level >= thr && tx_level < thr + trig);
        chk("fifo full", 0, link.fifo_full);
        apb(1'b0, APB_STATUS, 32'h0);
        chk("status", 32'h3, rd & 32'h0000000B);
        apb(1'b1, APB_THRESHOLD, 32'h0A);
        apb(1'b0, APB_THRESHOLD, 32'h0);
        chk("busy write", {26'h0, thr}, rd);
        apb(1'b1, APB_CMD, 32'h0);
        n = 0;
        while (tx_level !== 7'h00 && n < 70) begin
            tx_pop <= 1'b1;
            @(posedge clk);
            tx_pop <= 1'b0;
            @(posedge clk);
            chk("popped data", exp_pop, tx_data);
            exp_pop = exp_pop + 8'h01;
            n++;
        end
        chk("drained", 0, tx_level);
        $display("test run threshold %0d trigger %0d done", thr, trig);
    endtask : run_cfg
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, APB_THRESHOLD, 32'h0);
        chk("threshold reset", 32'h3E, rd);
        apb(1'b0, APB_TRIGGER, 32'h0);
        chk("trigger reset", 32'h1, rd);
        apb(1'b0, APB_STATUS, 32'h0);
        chk("status reset", 32'h2, rd & 32'h3);
        $display("test reset values done");
        run_cfg(6'h3E, 6'h01);
        run_cfg(6'h26, 6'h05);
        wq.delete();
        apb(1'b1, APB_THRESHOLD, 32'h3F);
        apb(1'b1, APB_TRIGGER, 32'h1);
        apb(1'b1, APB_CMD, 32'h1);
        repeat (12) @(posedge clk);
        chk("refused setup", 0, wq.size());
        apb(1'b0, APB_STATUS, 32'h0);
        chk("refused status", 0, rd & 32'h3);
        $display("test sum limit done");
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule : tb_top

// File: tb/utxdt_assertions.sv
`timescale 1ns/1ps
// ************************************************************
// link checker
// ************************************************************
module utxdt_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link signals
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic push,
    input wire logic dma_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // first write of the setup burst
    wire unlock = reg_wr && reg_addr == 8'h0C && reg_wdata == 8'hBF;
    a_map_unlock: assert property (unlock |=> reg_wr && reg_addr == 8'h08 && reg_wdata == 8'h10)
        else $error("enhanced unlock write missing");
    a_map_restore: assert property (unlock |-> ##2 reg_wr && reg_addr == 8'h0C && reg_wdata == 8'h00)
        else $error("normal map restore missing");
    a_gran_select: assert property (unlock |-> ##3 reg_wr && reg_addr == 8'h40 && reg_wdata == 8'h40)
        else $error("granularity select missing");
    a_trig_access: assert property (unlock |-> ##4 reg_wr && reg_addr == 8'h10 && reg_wdata == 8'h40)
        else $error("trigger access enable missing");
    a_trig_split: assert property (unlock |-> ##5 (reg_wr && reg_addr == 8'h1C && reg_wdata[7:4] == 4'h0) ##1 (reg_wr && reg_addr == 8'h08 && reg_wdata[3:0] == 4'h0))
        else $error("trigger level split wrong");
    a_dma_enable: assert property (unlock |-> ##7 reg_wr && reg_addr == 8'h80 && reg_wdata == 8'h04)
        else $error("threshold mode enable missing");
    a_thr_load: assert property (unlock |-> ##8 reg_wr && reg_addr == 8'h84 && reg_wdata[7:6] == 2'b00)
        else $error("threshold load missing");
    a_burst_len: assert property (unlock |-> reg_wr [*8] ##1 reg_wr ##1 !reg_wr)
        else $error("setup burst length wrong");
    a_push_req: assert property (push |-> dma_req)
        else $error("push without request");
endmodule : utxdt_assertions
